// *** inc/ram_fifo_pkg.sv ***
// shared constants, types and field layout for the embedded ram / fifo block
// assumes a single clock domain; fabric ports and register port run on clk
package ram_fifo_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 18;
  localparam int CNT_W = 13;
  localparam int BITS = 4608;
  localparam int INT_W = 6;

  typedef enum logic [2:0] {width_1, width_2, width_4, width_9, width_18} width_e;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wr_req_s;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
  } rd_req_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

  // register byte offsets
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_AE_THR = 8'h04;
  localparam logic [7:0] REG_AF_THR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_INT_STAT = 8'h10;
  localparam logic [7:0] REG_INT_EN = 8'h14;
  localparam logic [7:0] REG_INT_CLR = 8'h18;

  // field positions
  localparam int CFG_FIFO_BIT = 0;
  localparam int CFG_PIPE_BIT = 1;
  localparam int CFG_STOP_BIT = 2;
  localparam int CFG_WIDTH_LSB = 4;
  localparam int STAT_COUNT_LSB = 16;
  localparam int INT_EMPTY = 0;
  localparam int INT_FULL = 1;
  localparam int INT_AEMPTY = 2;
  localparam int INT_AFULL = 3;
  localparam int INT_OVER = 4;
  localparam int INT_UNDER = 5;

  // values after reset
  localparam logic [31:0] CFG_RESET = 32'h0000_0044;
  localparam logic [CNT_W-1:0] AE_RESET = 13'h0001;
  localparam logic [CNT_W-1:0] AF_RESET = 13'h00FF;

  function automatic logic [CNT_W-1:0] depth_of(input width_e w);
    case (w)
      width_1: depth_of = 13'h1000;
      width_2: depth_of = 13'h0800;
      width_4: depth_of = 13'h0400;
      width_9: depth_of = 13'h0200;
      default: depth_of = 13'h0100;
    endcase
  endfunction : depth_of

  // first bit of a word; narrow words pack 8 data bits per 9-bit row
  function automatic logic [12:0] bit_base(input width_e w, input logic [ADDR_W-1:0] a);
    case (w)
      width_1: bit_base = 13'(a[11:3]) * 13'h009 + 13'(a[2:0]);
      width_2: bit_base = 13'(a[10:2]) * 13'h009 + 13'({a[1:0], 1'b0});
      width_4: bit_base = 13'(a[9:1]) * 13'h009 + 13'({a[0], 2'b00});
      width_9: bit_base = 13'(a[8:0]) * 13'h009;
      default: bit_base = 13'(a[7:0]) * 13'h012;
    endcase
  endfunction : bit_base
endpackage : ram_fifo_pkg

// *** logic/ram_bit_store.sv ***
// bit array of the memory block with aspect-ratio write and read ports
// assumes the caller never asks for write and init shift in one cycle
module ram_bit_store
  import ram_fifo_pkg::*;
(
  input wire logic clk,
  input wire width_e mode,
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [ADDR_W-1:0] raddr,
  output logic [DATA_W-1:0] rdata,
  input wire logic init_sel,
  input wire logic init_shift,
  input wire logic init_sdi,
  output logic init_sdo
);
  logic [BITS-1:0] bits;
  logic [12:0] wbase;
  logic [12:0] rbase;

  assign wbase = bit_base(mode, waddr);
  assign rbase = bit_base(mode, raddr);
  assign init_sdo = bits[BITS-1];

  // contents carry no reset: they are loaded by shifting or by writes
  always_ff @(posedge clk)
  begin
    if (init_sel && init_shift)
    begin
      bits <= {bits[BITS-2:0], init_sdi};
    end
    else if (we)
    begin
      case (mode)
        width_1: bits[wbase +: 1] <= wdata[0:0];
        width_2: bits[wbase +: 2] <= wdata[1:0];
        width_4: bits[wbase +: 4] <= wdata[3:0];
        width_9: bits[wbase +: 9] <= wdata[8:0];
        default: bits[wbase +: 18] <= wdata;
      endcase
    end
  end

  always_comb
  begin
    rdata = '0;
    case (mode)
      width_1: rdata[0:0] = bits[rbase +: 1];
      width_2: rdata[1:0] = bits[rbase +: 2];
      width_4: rdata[3:0] = bits[rbase +: 4];
      width_9: rdata[8:0] = bits[rbase +: 9];
      default: rdata = bits[rbase +: 18];
    endcase
  end

  property p_shift_in;
    @(posedge clk) (init_sel && init_shift) |=> bits[0] == $past(init_sdi);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("init shift lost serial bit");

  property p_write_full_word;
    @(posedge clk) (we && !(init_sel && init_shift) && mode == width_18 && waddr == raddr)
      |=> (rdata == $past(wdata)) || (raddr != $past(raddr)) || mode != width_18;
  endproperty
  a_write_full_word: assert property (p_write_full_word) else $error("written word not stored");
endmodule : ram_bit_store

// *** logic/embedded_ram_fifo_block.sv ***
// embedded memory block: two-port ram with optional read pipeline, or fifo with flags
// assumes fabric inputs are synchronous to clk; edge choice is made by inverting clk outside
// Summary of operation
// - the array samples every input on the rising clock edge only; falling edge needs an inverted clock.
// - in dual-port use each port takes its own clock and edge, here both ports share one rising clock.
// - in two-port use writes follow the write clock and reads the read clock, either edge by inversion.
// - with the pipeline off the read address is taken at the edge with read enable and data follows that cycle.
// - with the pipeline on the read data is registered again and shows after the second read edge.
// - a write stores data at the address on an edge where write enable is high, inputs held valid there.
// - the whole array can be loaded at power-up by one serial shift through a selectable chain.
// - the fifo supports 4096x1, 2048x2, 1024x4, 512x9 and 256x18 organisations.
// - the fifo drives empty, full, almost-empty and almost-full outputs.
// - empty is produced in the read clock domain.
// - full is produced in the write clock domain.
// - almost-empty and almost-full compare against separately programmed thresholds.
// - fifo reset is active-low asynchronous, block enable and write enable active-low, read enable active-high.
// - the pointers either stop at empty and full or run on past them, by configuration; the occupancy count saturates.
module embedded_ram_fifo_block
  import ram_fifo_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire bus_req_s bus,
  output logic [31:0] bus_rdata,
  input wire wr_req_s wr,
  input wire rd_req_s rd,
  input wire logic fifo_rst_n,
  input wire logic blk_n,
  input wire logic wen_n,
  input wire logic ren,
  input wire logic [DATA_W-1:0] fifo_wdata,
  output logic [DATA_W-1:0] rd_data,
  output logic empty,
  output logic full,
  output logic almost_empty,
  output logic almost_full,
  input wire logic init_sel,
  input wire logic init_shift,
  input wire logic init_sdi,
  output logic init_sdo,
  output logic irq
);
  logic fifo_mode;
  logic pipe;
  logic stop;
  width_e width;
  logic [CNT_W-1:0] ae_thr;
  logic [CNT_W-1:0] af_thr;
  logic [INT_W-1:0] int_en;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_clr;
  logic [INT_W-1:0] events;
  logic [3:0] prev_flags;
  logic [ADDR_W-1:0] wptr;
  logic [ADDR_W-1:0] rptr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] depth;
  logic [ADDR_W-1:0] ptr_mask;
  logic any_rst;
  logic push_req;
  logic pop_req;
  logic push;
  logic pop;
  logic mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic [ADDR_W-1:0] mem_raddr;
  logic [DATA_W-1:0] mem_rdata;
  logic rd_fire;
  logic [DATA_W-1:0] rd_first;
  logic [DATA_W-1:0] rd_second;
  logic cfg_wr;

  // a fifo reset also clears the pointers; both resets act without the clock
  assign any_rst = rst | ~fifo_rst_n;
  assign depth = depth_of(width);
  assign ptr_mask = ADDR_W'(depth - 13'h0001);

  assign push_req = fifo_mode & ~blk_n & ~wen_n;
  assign pop_req = fifo_mode & ~blk_n & ren;
  assign push = push_req & (~full | ~stop);
  assign pop = pop_req & (~empty | ~stop);

  assign empty = (count == '0);
  assign full = (count >= depth);
  assign almost_empty = (count <= ae_thr);
  assign almost_full = (count >= af_thr);

  // ram ports are idle in fifo mode so the two users never collide
  assign mem_we = fifo_mode ? push : wr.en;
  assign mem_waddr = fifo_mode ? wptr : wr.addr;
  assign mem_wdata = fifo_mode ? fifo_wdata : wr.data;
  assign rd_fire = fifo_mode ? pop : rd.en;
  assign mem_raddr = fifo_mode ? rptr : rd.addr;

  ram_bit_store store
  (
    .clk(clk),
    .mode(width),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata),
    .init_sel(init_sel),
    .init_shift(init_shift),
    .init_sdi(init_sdi),
    .init_sdo(init_sdo)
  );

  assign cfg_wr = bus.wr && bus.addr == REG_CFG;

  // configuration written by software steers mode, pipeline, counting and width
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fifo_mode <= CFG_RESET[CFG_FIFO_BIT];
      pipe <= CFG_RESET[CFG_PIPE_BIT];
      stop <= CFG_RESET[CFG_STOP_BIT];
      width <= width_e'(CFG_RESET[CFG_WIDTH_LSB +: 3]);
      ae_thr <= AE_RESET;
      af_thr <= AF_RESET;
      int_en <= '0;
    end
    else if (bus.wr)
    begin
      if (cfg_wr)
      begin
        fifo_mode <= bus.wdata[CFG_FIFO_BIT];
        pipe <= bus.wdata[CFG_PIPE_BIT];
        stop <= bus.wdata[CFG_STOP_BIT];
        width <= width_e'(bus.wdata[CFG_WIDTH_LSB +: 3]);
      end
      if (bus.addr == REG_AE_THR)
      begin
        ae_thr <= bus.wdata[CNT_W-1:0];
      end
      if (bus.addr == REG_AF_THR)
      begin
        af_thr <= bus.wdata[CNT_W-1:0];
      end
      if (bus.addr == REG_INT_EN)
      begin
        int_en <= bus.wdata[INT_W-1:0];
      end
    end
  end

  // occupancy saturates at 0 and depth; in continue mode only the pointers run on
  always_comb
  begin
    next_count = count;
    if (push && !pop && count < depth)
    begin
      next_count = count + 13'h0001;
    end
    else if (pop && !push && count != '0)
    begin
      next_count = count - 13'h0001;
    end
  end

  always_ff @(posedge clk or posedge any_rst)
  begin
    if (any_rst)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr <= (wptr + 12'h001) & ptr_mask;
      end
      if (pop)
      begin
        rptr <= (rptr + 12'h001) & ptr_mask;
      end
      count <= next_count;
    end
  end

  // read data stage and optional second stage, both flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_first <= '0;
      rd_second <= '0;
    end
    else
    begin
      if (rd_fire)
      begin
        rd_first <= mem_rdata;
      end
      rd_second <= rd_first;
    end
  end

  assign rd_data = pipe ? rd_second : rd_first;

  // rising flag edges and requests made while full or empty raise sticky events
  assign events[INT_EMPTY] = empty & ~prev_flags[0];
  assign events[INT_FULL] = full & ~prev_flags[1];
  assign events[INT_AEMPTY] = almost_empty & ~prev_flags[2];
  assign events[INT_AFULL] = almost_full & ~prev_flags[3];
  assign events[INT_OVER] = push_req & full;
  assign events[INT_UNDER] = pop_req & empty;
  assign int_clr = (bus.wr && bus.addr == REG_INT_CLR) ? bus.wdata[INT_W-1:0] : '0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_flags <= 4'h5;
      int_stat <= '0;
    end
    else
    begin
      prev_flags <= {almost_full, almost_empty, full, empty};
      // a new event beats a clear in the same cycle
      int_stat <= (int_stat & ~int_clr) | events;
    end
  end

  assign irq = |(int_stat & int_en);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_rdata <= '0;
    end
    else
    begin
      bus_rdata <= '0;
      if (bus.rd)
      begin
        case (bus.addr)
          REG_CFG: bus_rdata <= {25'h0, width, 1'b0, stop, pipe, fifo_mode};
          REG_AE_THR: bus_rdata <= {19'h0, ae_thr};
          REG_AF_THR: bus_rdata <= {19'h0, af_thr};
          REG_STATUS: bus_rdata <= {3'h0, count, 12'h0, almost_full, almost_empty, full, empty};
          REG_INT_STAT: bus_rdata <= {26'h0, int_stat};
          REG_INT_EN: bus_rdata <= {26'h0, int_en};
          default: bus_rdata <= '0;
        endcase
      end
    end
  end

  property p_stop_full;
    @(posedge clk) disable iff (any_rst)
      (stop && full && push_req && !pop_req) |=> (count == $past(count)) && (wptr == $past(wptr));
  endproperty
  a_stop_full: assert property (p_stop_full) else $error("write taken while full");

  property p_stop_empty;
    @(posedge clk) disable iff (any_rst)
      (stop && empty && pop_req && !push_req) |=> $stable(rptr) && count == '0;
  endproperty
  a_stop_empty: assert property (p_stop_empty) else $error("read taken while empty");

  property p_count_up;
    @(posedge clk) disable iff (any_rst)
      (push && !pop && count < depth && !cfg_wr) |=> count == $past(count) + 13'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("occupancy did not advance");

  property p_full_set;
    @(posedge clk) disable iff (any_rst)
      (push && !pop && count == depth - 13'h0001 && !cfg_wr) |=> full;
  endproperty
  a_full_set: assert property (p_full_set) else $error("full not raised on last write");

  property p_ae_set;
    @(posedge clk) disable iff (any_rst)
      (pop && !push && count != '0 && ae_thr != '0 && count - 13'h0001 == ae_thr && !bus.wr)
      |=> almost_empty && !empty;
  endproperty
  a_ae_set: assert property (p_ae_set) else $error("almost empty missed threshold");

  property p_af_set;
    @(posedge clk) disable iff (any_rst)
      (push && !pop && count + 13'h0001 == af_thr && count < depth && !bus.wr) |=> almost_full;
  endproperty
  a_af_set: assert property (p_af_set) else $error("almost full missed threshold");

  property p_rd_nonpipe;
    @(posedge clk) disable iff (rst)
      (rd_fire && !pipe) ##1 !pipe |-> rd_data == $past(mem_rdata);
  endproperty
  a_rd_nonpipe: assert property (p_rd_nonpipe) else $error("read data late without pipeline");

  property p_rd_pipe;
    @(posedge clk) disable iff (rst)
      (rd_fire && pipe) ##1 pipe ##1 pipe |-> rd_data == $past(mem_rdata, 2);
  endproperty
  a_rd_pipe: assert property (p_rd_pipe) else $error("pipelined read data wrong");

  property p_overflow_irq;
    @(posedge clk) disable iff (rst)
      (push_req && full) |=> int_stat[INT_OVER] && (irq || !int_en[INT_OVER]);
  endproperty
  a_overflow_irq: assert property (p_overflow_irq) else $error("overflow event not flagged");

  property p_fifo_rst;
    @(posedge clk) disable iff (rst)
      $rose(fifo_rst_n) |-> empty && count == '0 && wptr == '0;
  endproperty
  a_fifo_rst: assert property (p_fifo_rst) else $error("fifo not empty after reset");
endmodule : embedded_ram_fifo_block

// *** verif/fabric_model.sv ***
// fabric-side model: user logic that drives the ram and fifo ports of the memory block
// assumes clk is the block clock and that the bench calls one task at a time
module fabric_model
  import ram_fifo_pkg::*;
(
  input wire logic clk,
  input wire logic [DATA_W-1:0] rd_data,
  output wr_req_s wr,
  output rd_req_s rd,
  output logic fifo_rst_n,
  output logic blk_n,
  output logic wen_n,
  output logic ren,
  output logic [DATA_W-1:0] fifo_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    wr = '0;
    rd = '0;
    fifo_rst_n = 1'b1;
    blk_n = 1'b1;
    wen_n = 1'b1;
    ren = 1'b0;
    fifo_wdata = '0;
  end

  task automatic ram_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic en);
    @(posedge clk);
    wr <= '{en, a, d};
    @(posedge clk);
    // released lines show the inverse so a stale word cannot pass for a good one
    wr <= '{1'b0, ~a, ~d};
  endtask : ram_write

  // d1 is sampled one cycle after the address edge, d2 one cycle later
  task automatic ram_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d1,
    output logic [DATA_W-1:0] d2);
    @(posedge clk);
    rd <= '{1'b1, a};
    @(posedge clk);
    rd <= '{1'b0, ~a};
    #1 d1 = rd_data;
    @(posedge clk);
    #1 d2 = rd_data;
  endtask : ram_read

  task automatic fifo_op(input logic push, input logic pop, input logic blk, input logic [DATA_W-1:0] d,
    output logic [DATA_W-1:0] q);
    @(posedge clk);
    blk_n <= blk;
    wen_n <= ~push;
    ren <= pop;
    fifo_wdata <= d;
    @(posedge clk);
    blk_n <= 1'b1;
    wen_n <= 1'b1;
    ren <= 1'b0;
    fifo_wdata <= ~d;
    #1 q = rd_data;
  endtask : fifo_op

  task automatic fifo_clear();
    @(posedge clk);
    fifo_rst_n <= 1'b0;
    @(posedge clk);
    fifo_rst_n <= 1'b1;
  endtask : fifo_clear
endmodule : fabric_model

// *** verif/testbench.sv ***
// self-checking bench for the embedded ram / fifo block: register port plus fabric model
// assumes one clock; the serial load chain is driven directly by the bench at the end of the run
module testbench;
  import ram_fifo_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  bus_req_s bus = '0;
  logic [31:0] bus_rdata;
  wr_req_s wr;
  rd_req_s rd;
  logic fifo_rst_n, blk_n, wen_n, ren;
  logic [DATA_W-1:0] fifo_wdata, rd_data, q1, q2;
  logic empty, full, almost_empty, almost_full, irq;
  logic init_sel = 1'b0;
  logic init_shift = 1'b0;
  logic init_sdi = 1'b0;
  logic init_sdo;
  int errors = 0;
  int n_checks = 0;
  int depth, mask;
  int bits[5] = '{1, 2, 4, 9, 18};

  always #2 clk = ~clk;

  embedded_ram_fifo_block embedded_ram_fifo_block_i (.clk(clk), .rst(rst), .bus(bus), .bus_rdata(bus_rdata),
    .wr(wr), .rd(rd), .fifo_rst_n(fifo_rst_n), .blk_n(blk_n), .wen_n(wen_n), .ren(ren),
    .fifo_wdata(fifo_wdata), .rd_data(rd_data), .empty(empty), .full(full), .almost_empty(almost_empty),
    .almost_full(almost_full), .init_sel(init_sel), .init_shift(init_shift), .init_sdi(init_sdi),
    .init_sdo(init_sdo), .irq(irq));

  fabric_model fabric_model_i (.clk(clk), .rd_data(rd_data), .wr(wr), .rd(rd), .fifo_rst_n(fifo_rst_n),
    .blk_n(blk_n), .wen_n(wen_n), .ren(ren), .fifo_wdata(fifo_wdata));

  task automatic conclude();
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '0;
  endtask : bus_wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk);
    bus <= '0;
    #1 check($sformatf("register %h", a), bus_rdata, exp);
  endtask : rchk

  // empty pop, push, pop: a stopped fifo hands back the pushed word, a free-running one the next slot
  task automatic stop_case(input logic [31:0] cfg, input logic [31:0] exp);
    bus_wr(REG_CFG, cfg);
    fabric_model_i.fifo_clear();
    fabric_model_i.fifo_op(1'b0, 1'b1, 1'b0, 18'h00000, q1);
    check("empty after empty pop", 32'(empty), 32'h1);
    fabric_model_i.fifo_op(1'b1, 1'b0, 1'b0, 18'h2F0F0, q1);
    fabric_model_i.fifo_op(1'b0, 1'b1, 1'b0, 18'h00000, q1);
    check("word after empty pop", 32'(q1), exp);
  endtask : stop_case

  // hang guard; the normal run needs far fewer cycles
  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    conclude();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(REG_CFG, 32'h0000_0044);
    rchk(REG_AE_THR, 32'h0000_0001);
    rchk(REG_AF_THR, 32'h0000_00FF);
    rchk(REG_STATUS, 32'h0000_0005);
    rchk(REG_INT_STAT, 32'h0000_0000);
    rchk(8'h1C, 32'h0000_0000);
    bus_wr(REG_CFG, 32'h0000_0040);
    fabric_model_i.ram_write(12'h005, 18'h2ABCD, 1'b1);
    fabric_model_i.ram_write(12'h006, 18'h01234, 1'b1);
    fabric_model_i.ram_write(12'h005, 18'h11111, 1'b0);
    fabric_model_i.ram_read(12'h005, q1, q2);
    check("ram read", 32'(q1), 32'h0002_ABCD);
    check("ram read hold", 32'(q2), 32'h0002_ABCD);
    bus_wr(REG_CFG, 32'h0000_0042);
    fabric_model_i.ram_read(12'h006, q1, q2);
    check("pipe first edge", 32'(q1), 32'h0002_ABCD);
    check("pipe second edge", 32'(q2), 32'h0000_1234);
    for (int w = 0; w < 5; w++)
    begin
      depth = 4096 >> w;
      mask = (1 << bits[w]) - 1;
      bus_wr(REG_CFG, 32'h0000_0005 | 32'(w << 4));
      bus_wr(REG_AE_THR, 32'h0000_0002);
      bus_wr(REG_AF_THR, 32'(depth - 2));
      fabric_model_i.fifo_clear();
      fabric_model_i.fifo_op(1'b1, 1'b0, 1'b1, 18'h00003, q1);
      check("push with block off", 32'(empty), 32'h1);
      for (int i = 1; i <= depth; i++)
      begin
        fabric_model_i.fifo_op(1'b1, 1'b0, 1'b0, 18'(((i - 1) * 5 + 3) & mask), q1);
        check("fill flags", {empty, full, almost_empty, almost_full},
          {1'b0, i == depth, i <= 2, i >= depth - 2});
      end
      rchk(REG_STATUS, 32'(depth << 16) | 32'h0000_000A);
      bus_wr(REG_INT_CLR, 32'h0000_003F);
      bus_wr(REG_INT_EN, 32'h0000_0030);
      fabric_model_i.fifo_op(1'b1, 1'b0, 1'b0, 18'h15555, q1);
      rchk(REG_INT_STAT, 32'h0000_0010);
      check("irq raised", 32'(irq), 32'h1);
      bus_wr(REG_INT_EN, 32'h0000_0000);
      #1 check("irq masked", 32'(irq), 32'h0);
      for (int i = 0; i < depth; i++)
      begin
        fabric_model_i.fifo_op(1'b0, 1'b1, 1'b0, 18'h00000, q1);
        check("pop data", 32'(q1), 32'((i * 5 + 3) & mask));
      end
      check("drain flags", {empty, full, almost_empty, almost_full}, 32'hA);
      fabric_model_i.fifo_op(1'b0, 1'b1, 1'b0, 18'h00000, q1);
      rchk(REG_INT_STAT, 32'h0000_0035);
      bus_wr(REG_INT_CLR, 32'h0000_003F);
      rchk(REG_INT_STAT, 32'h0000_0000);
    end
    stop_case(32'h0000_0045, 32'h0002_F0F0);
    stop_case(32'h0000_0041, 32'h0000_0008);
    // whole-array serial load: the first bit must reach the far end, the last 18 bits form word 0
    bus_wr(REG_CFG, 32'h0000_0040);
    for (int k = 0; k < BITS; k++)
    begin
      @(posedge clk);
      init_sel <= 1'b1;
      init_shift <= 1'b1;
      init_sdi <= (k == 0) || (k >= BITS - 18 && k % 2 == 1);
    end
    @(posedge clk);
    init_sel <= 1'b0;
    init_shift <= 1'b0;
    #1 check("serial load far end", 32'(init_sdo), 32'h1);
    fabric_model_i.ram_read(12'h000, q1, q2);
    check("serial load word", 32'(q1), 32'h0001_5555);
    conclude();
  end
endmodule : testbench
